/* inc/bt4_pkg.sv */
package bt4_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] BT4_IDX_IE2    = 8'hA9;
  localparam logic [7:0] BT4_IDX_IP2    = 8'hB9;
  localparam logic [7:0] BT4_IDX_CTRL   = 8'hC8;
  localparam logic [7:0] BT4_IDX_MODE   = 8'hC9;
  localparam logic [7:0] BT4_IDX_RLD_LO = 8'hCA;
  localparam logic [7:0] BT4_IDX_RLD_HI = 8'hCB;
  localparam logic [7:0] BT4_IDX_CNT_LO = 8'hCC;
  localparam logic [7:0] BT4_IDX_CNT_HI = 8'hCD;
  localparam logic [7:0] BT4_IDX_BANK   = 8'hCE;
  localparam logic [7:0] BT4_IDX_STAT   = 8'hD0;
  localparam logic [7:0] BT4_IDX_IEN    = 8'hD1;
  localparam logic [7:0] BT4_IDX_ICLR   = 8'hD2;

  // bank pointer code that selects this timer, and its reset value
  localparam logic [2:0] BT4_BANK_SEL   = 3'h4;
  localparam logic [2:0] BT4_BANK_RST   = 3'h2;

  // bit positions in the shared enable and priority registers
  localparam int unsigned BT4_IE2_BIT   = 7;
  localparam int unsigned BT4_IP2_BIT   = 7;

  // status layout: bit 0 overflow event, bit 1 trigger event
  localparam int unsigned BT4_ST_OVF    = 0;
  localparam int unsigned BT4_ST_EXT    = 1;
  localparam int unsigned BT4_ST_W      = 2;

  // reset values and counting constants
  localparam logic [7:0]  BT4_REG_RST   = 8'h00;
  localparam logic [15:0] BT4_CNT_TOP   = 16'hFFFF;
  localparam logic [15:0] BT4_CNT_ZERO  = 16'h0000;
  localparam logic [3:0]  BT4_PRESCALE  = 4'hC;

  // control register fields, msb first
  typedef struct packed {
    logic       overflow_flag;
    logic       external_event_flag;
    logic [1:0] reserved;
    logic       trigger_enable;
    logic       run_control;
    logic       counter_mode;
    logic       capture_reload_select;
  } bt4_ctrl_type;

  // mode register fields, msb first
  typedef struct packed {
    logic       count_source_select;
    logic       reserved;
    logic       pwm_channel_b_enable;
    logic       pwm_channel_a_enable;
    logic       pwm_channel_b_invert;
    logic       pwm_channel_a_invert;
    logic       clock_output_enable;
    logic       down_count_enable;
  } bt4_mode_type;

endpackage

/* src/bt4_banked_timer_four.sv */
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

// banked 16-bit timer/counter with wishbone register access
module bt4_banked_timer_four #(
  parameter logic [3:0] PRESCALE = bt4_pkg::BT4_PRESCALE
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // count pin: input in counter mode, clock output in clock-out mode
  input  wire logic        count_io_pin_i,
  output logic             count_io_pin_o,
  output logic             count_io_pin_oe,
  // trigger pin: capture/reload edge, or direction level
  input  wire logic        external_trigger_pin_i,
  // run state shared with the paired pwm counter
  output logic             paired_pwm_run,
  // pwm channel settings handed to the pwm block
  output logic [3:0]       pwm_channel_cfg,
  // interrupt request and its priority
  output logic             timer_irq,
  output logic             timer_irq_priority
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  bt4_pkg::bt4_ctrl_type ctrl_r;          // banked control register
  bt4_pkg::bt4_ctrl_type ctrl_nxt;        // its next value
  bt4_pkg::bt4_mode_type mode_r;          // banked mode register
  logic [7:0]            ie2_r;           // shared interrupt enable two
  logic [7:0]            ip2_r;           // shared interrupt priority two
  logic [2:0]            bank_r;          // register bank pointer
  logic [15:0]           cnt_r;           // the counter itself
  logic [15:0]           cnt_nxt;         // counter next value
  logic [15:0]           rld_r;           // reload / capture register
  logic [15:0]           rld_nxt;         // reload next value
  logic [3:0]            pre_r;           // fsys/12 prescaler
  logic                  cio_d_r;         // count pin, one cycle old
  logic                  trg_d_r;         // trigger pin, one cycle old
  logic                  half_r;          // overflow pair divider
  logic                  clk_out_r;       // clock output level
  logic [bt4_pkg::BT4_ST_W-1:0] stat_r;   // sticky event status
  logic [bt4_pkg::BT4_ST_W-1:0] ien_r;    // event enables
  logic                  ack_r;           // bus acknowledge
  logic [31:0]           rdat_r;          // registered read data

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic [7:0] idx      = wb_adr_i[9:2];           // register index
  wire logic       req      = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic       wr       = req & wb_we_i & wb_sel_i[0];
  wire logic [7:0] wd       = wb_dat_i[7:0];
  // banked registers only answer when the pointer selects this timer
  wire logic       bank_hit = (bank_r == bt4_pkg::BT4_BANK_SEL);

  wire logic wr_ie2  = wr & (idx == bt4_pkg::BT4_IDX_IE2);
  wire logic wr_ip2  = wr & (idx == bt4_pkg::BT4_IDX_IP2);
  wire logic wr_bank = wr & (idx == bt4_pkg::BT4_IDX_BANK);
  wire logic wr_ien  = wr & (idx == bt4_pkg::BT4_IDX_IEN);
  wire logic wr_iclr = wr & (idx == bt4_pkg::BT4_IDX_ICLR);
  wire logic wr_ctrl = wr & bank_hit & (idx == bt4_pkg::BT4_IDX_CTRL);
  wire logic wr_mode = wr & bank_hit & (idx == bt4_pkg::BT4_IDX_MODE);
  wire logic wr_rl   = wr & bank_hit & (idx == bt4_pkg::BT4_IDX_RLD_LO);
  wire logic wr_rh   = wr & bank_hit & (idx == bt4_pkg::BT4_IDX_RLD_HI);
  wire logic wr_cl   = wr & bank_hit & (idx == bt4_pkg::BT4_IDX_CNT_LO);
  wire logic wr_ch   = wr & bank_hit & (idx == bt4_pkg::BT4_IDX_CNT_HI);

  // read mux; banked slots read zero when another bank is selected
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      bt4_pkg::BT4_IDX_IE2:    rd_byte = ie2_r;
      bt4_pkg::BT4_IDX_IP2:    rd_byte = ip2_r;
      bt4_pkg::BT4_IDX_BANK:   rd_byte = {5'h00, bank_r};
      bt4_pkg::BT4_IDX_STAT:   rd_byte = {6'h00, stat_r};
      bt4_pkg::BT4_IDX_IEN:    rd_byte = {6'h00, ien_r};
      bt4_pkg::BT4_IDX_CTRL:   rd_byte = bank_hit ? {ctrl_r[7:6], 2'b00, ctrl_r[3:0]} : 8'h00;
      bt4_pkg::BT4_IDX_MODE:   rd_byte = bank_hit ? {mode_r[7], 1'b0, mode_r[5:0]} : 8'h00;
      bt4_pkg::BT4_IDX_RLD_LO: rd_byte = bank_hit ? rld_r[7:0] : 8'h00;
      bt4_pkg::BT4_IDX_RLD_HI: rd_byte = bank_hit ? rld_r[15:8] : 8'h00;
      bt4_pkg::BT4_IDX_CNT_LO: rd_byte = bank_hit ? cnt_r[7:0] : 8'h00;
      bt4_pkg::BT4_IDX_CNT_HI: rd_byte = bank_hit ? cnt_r[15:8] : 8'h00;
      // clear register is write-only; unmapped indices read zero
      default:                 rd_byte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // clock-out needs timer mode; counter mode keeps the pin an input
  wire logic clkout_mode = mode_r.clock_output_enable & ~ctrl_r.counter_mode;
  // direction from the trigger pin only in reload mode with down enabled
  wire logic dn_mode     = mode_r.down_count_enable & ~ctrl_r.capture_reload_select
                           & ~clkout_mode;
  wire logic count_down  = dn_mode & ~external_trigger_pin_i;

  // ---------------------------------------------------------------
  // count source
  // ---------------------------------------------------------------
  wire logic pre_wrap   = (pre_r == PRESCALE - 4'h1);
  // fsys/12 when the source bit is low, every clock when high
  wire logic tick_timer = mode_r.count_source_select | pre_wrap;
  // inputs are synchronous; a one-cycle-old copy finds falling edges
  wire logic cio_fall   = cio_d_r & ~count_io_pin_i;
  wire logic tick_src   = ctrl_r.counter_mode ? cio_fall : tick_timer;
  wire logic tick       = ctrl_r.run_control & tick_src;

  // ---------------------------------------------------------------
  // overflow and trigger events
  // ---------------------------------------------------------------
  wire logic top_hit  = (cnt_r == bt4_pkg::BT4_CNT_TOP);
  wire logic bot_hit  = (cnt_r == rld_r);
  wire logic ovf      = tick & (count_down ? bot_hit : top_hit);
  wire logic trg_fall = trg_d_r & ~external_trigger_pin_i;
  // trigger edges ignored unless enabled; in down mode the pin is a level only
  wire logic trg_evt  = ctrl_r.trigger_enable & trg_fall & ~dn_mode;
  wire logic cap_evt  = trg_evt & ctrl_r.capture_reload_select & ~clkout_mode;
  wire logic rld_evt  = trg_evt & ~ctrl_r.capture_reload_select & ~clkout_mode;
  // clock-out overflows raise no flag and no interrupt
  wire logic ovf_set  = ovf & ~clkout_mode;
  // in down mode the event flag acts as a 17th count bit
  wire logic ext_tog  = ovf & dn_mode;

  // ---------------------------------------------------------------
  // counter next value
  // ---------------------------------------------------------------
  logic [15:0] cnt_hw;
  always_comb begin
    cnt_hw = cnt_r;
    if (ovf) begin
      if (count_down) begin
        cnt_hw = bt4_pkg::BT4_CNT_TOP;
      end else if (ctrl_r.capture_reload_select & ~clkout_mode) begin
        // capture mode has no reload: plain 16-bit wrap
        cnt_hw = bt4_pkg::BT4_CNT_ZERO;
      end else begin
        cnt_hw = rld_r;
      end
    end else if (tick) begin
      cnt_hw = count_down ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
    end else if (rld_evt) begin
      // a trigger edge forces a reload even with the timer stopped
      cnt_hw = rld_r;
    end
  end
  // software byte writes win over counting in the same cycle
  assign cnt_nxt = {wr_ch ? wd : cnt_hw[15:8], wr_cl ? wd : cnt_hw[7:0]};

  // capture copies the live counter; software writes take precedence
  wire logic [15:0] rld_hw = cap_evt ? cnt_r : rld_r;
  assign rld_nxt = {wr_rh ? wd : rld_hw[15:8], wr_rl ? wd : rld_hw[7:0]};

  // ---------------------------------------------------------------
  // control register next value: hardware set beats software clear
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt          = bt4_pkg::bt4_ctrl_type'(wd);
      ctrl_nxt.reserved = 2'b00;
    end
    if (ovf_set) begin
      ctrl_nxt.overflow_flag = 1'b1;
    end
    if (trg_evt) begin
      ctrl_nxt.external_event_flag = 1'b1;
    end else if (ext_tog) begin
      ctrl_nxt.external_event_flag = ~ctrl_r.external_event_flag;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status: sticky, set wins over the clear register
  // ---------------------------------------------------------------
  wire logic [bt4_pkg::BT4_ST_W-1:0] st_set = {trg_evt, ovf_set};
  wire logic [bt4_pkg::BT4_ST_W-1:0] st_clr = wr_iclr ? wd[bt4_pkg::BT4_ST_W-1:0]
                                                      : {bt4_pkg::BT4_ST_W{1'b0}};
  wire logic [bt4_pkg::BT4_ST_W-1:0] st_nxt = (stat_r & ~st_clr) | st_set;

  // ---------------------------------------------------------------
  // clock output: toggle every second overflow, 50% duty
  // ---------------------------------------------------------------
  // one output period spans four overflows, giving fn/(4*(65536-reload))
  wire logic clk_flip = clkout_mode & ovf & half_r;

  // ---------------------------------------------------------------
  // bus handshake and shared registers
  // ---------------------------------------------------------------
  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= req;
      rdat_r <= {24'h00_0000, rd_byte};
    end
  end

  // registers outside the bank: enable, priority, pointer, irq masks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ie2_r  <= bt4_pkg::BT4_REG_RST;
      ip2_r  <= bt4_pkg::BT4_REG_RST;
      bank_r <= bt4_pkg::BT4_BANK_RST;
      ien_r  <= {bt4_pkg::BT4_ST_W{1'b0}};
    end else begin
      if (wr_ie2) begin
        ie2_r <= {wd[7:5], 1'b0, wd[3:0]};
      end
      if (wr_ip2) begin
        ip2_r <= {wd[7:5], 1'b0, wd[3:0]};
      end
      if (wr_bank) begin
        bank_r <= wd[2:0];
      end
      if (wr_ien) begin
        ien_r <= wd[bt4_pkg::BT4_ST_W-1:0];
      end
    end
  end

  // banked control and mode registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= bt4_pkg::bt4_ctrl_type'(bt4_pkg::BT4_REG_RST);
      mode_r <= bt4_pkg::bt4_mode_type'(bt4_pkg::BT4_REG_RST);
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_mode) begin
        mode_r          <= bt4_pkg::bt4_mode_type'(wd);
        mode_r.reserved <= 1'b0;
      end
    end
  end

  // counter, reload/capture and the sticky status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= bt4_pkg::BT4_CNT_ZERO;
      rld_r  <= bt4_pkg::BT4_CNT_ZERO;
      stat_r <= {bt4_pkg::BT4_ST_W{1'b0}};
    end else begin
      cnt_r  <= cnt_nxt;
      rld_r  <= rld_nxt;
      stat_r <= st_nxt;
    end
  end

  // prescaler runs only with the timer, so each start begins a full /12
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 4'h0;
    end else if (!ctrl_r.run_control || pre_wrap) begin
      pre_r <= 4'h0;
    end else begin
      pre_r <= pre_r + 4'h1;
    end
  end

  // pin history for edge detection; idle-high so reset sees no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cio_d_r <= 1'b1;
      trg_d_r <= 1'b1;
    end else begin
      cio_d_r <= count_io_pin_i;
      trg_d_r <= external_trigger_pin_i;
    end
  end

  // clock-out divider; parked low whenever the mode is off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r    <= 1'b0;
      clk_out_r <= 1'b0;
    end else if (!clkout_mode) begin
      half_r    <= 1'b0;
      clk_out_r <= 1'b0;
    end else begin
      if (ovf) begin
        half_r <= ~half_r;
      end
      if (clk_flip) begin
        clk_out_r <= ~clk_out_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_o        = ack_r;
  assign wb_dat_o        = rdat_r;
  // pin drives only in clock-out mode; otherwise an input or plain i/o
  assign count_io_pin_o  = clk_out_r;
  assign count_io_pin_oe = clkout_mode;
  // one run bit steers both this counter and the paired pwm counter
  assign paired_pwm_run  = ctrl_r.run_control;
  assign pwm_channel_cfg = mode_r[5:2];
  // the shared enable bit gates every enabled sticky event
  assign timer_irq       = ie2_r[bt4_pkg::BT4_IE2_BIT] & |(stat_r & ien_r);
  assign timer_irq_priority = ip2_r[bt4_pkg::BT4_IP2_BIT];
  // only capture, auto-reload and clock-out exist here; no baud path

endmodule

`default_nettype wire

/* tb/bt4_asserts.sv */
`timescale 1ns/10ps
`default_nettype none

// port-level checker; shadows only the few register bits that software alone writes
module bt4_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        count_io_pin_o,
  input wire logic        count_io_pin_oe,
  input wire logic        paired_pwm_run,
  input wire logic [3:0]  pwm_channel_cfg,
  input wire logic        timer_irq,
  input wire logic        timer_irq_priority
);
  wire logic       take = wb_cyc_i & wb_stb_i & ~wb_ack_o;  // request taken at this edge
  wire logic       wr   = take & wb_we_i & wb_sel_i[0];     // write that lands
  wire logic [7:0] idx  = wb_adr_i[9:2];                   // register index
  logic [2:0]      bank_r;                                 // shadow bank pointer
  logic            ie2_r;                                  // shadow timer irq enable
  logic            oe_r;                                   // shadow clock-out bit
  logic            cm_r;                                   // shadow counter-mode bit

  // shadows follow software writes; hardware never changes these bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_r <= bt4_pkg::BT4_BANK_RST;
      ie2_r  <= 1'b0;
      oe_r   <= 1'b0;
      cm_r   <= 1'b0;
    end else if (wr) begin
      if (idx == bt4_pkg::BT4_IDX_BANK) bank_r <= wb_dat_i[2:0];
      if (idx == bt4_pkg::BT4_IDX_IE2) ie2_r <= wb_dat_i[7];
      if (idx == bt4_pkg::BT4_IDX_MODE && bank_r == bt4_pkg::BT4_BANK_SEL) oe_r <= wb_dat_i[1];
      if (idx == bt4_pkg::BT4_IDX_CTRL && bank_r == bt4_pkg::BT4_BANK_SEL) cm_r <= wb_dat_i[1];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a landed write to one index, and one that only counts while the bank is ours
  sequence s_wr(logic [7:0] i);
    wr && idx == i;
  endsequence
  sequence s_wr_sel(logic [7:0] i);
    wr && idx == i && bank_r == bt4_pkg::BT4_BANK_SEL;
  endsequence

  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_TAKE: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_REQ: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
    else $error("ack without request");
  AST_DAT_HI: assert property (wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  AST_PRIO_WR: assert property (s_wr(bt4_pkg::BT4_IDX_IP2) |=>
      timer_irq_priority == $past(wb_dat_i[7]))
    else $error("priority output does not follow write");
  AST_PRIO_RD: assert property (take && !wb_we_i && idx == bt4_pkg::BT4_IDX_IP2 |=>
      wb_dat_o[7] == timer_irq_priority)
    else $error("priority readback wrong");
  AST_RUN_WR: assert property (s_wr_sel(bt4_pkg::BT4_IDX_CTRL) |=>
      paired_pwm_run == $past(wb_dat_i[2]))
    else $error("run output does not follow control write");
  AST_CFG_WR: assert property (s_wr_sel(bt4_pkg::BT4_IDX_MODE) |=>
      pwm_channel_cfg == $past(wb_dat_i[5:2]))
    else $error("pwm settings do not follow mode write");
  AST_BANK_GUARD: assert property (wr && idx == bt4_pkg::BT4_IDX_CTRL &&
      bank_r != bt4_pkg::BT4_BANK_SEL |=> $stable(paired_pwm_run))
    else $error("control write acted while bank not selected");
  AST_IRQ_GATE: assert property (timer_irq |-> ie2_r)
    else $error("interrupt while enable bit clear");
  AST_OE: assert property (count_io_pin_oe == (oe_r & !cm_r))
    else $error("clock output enable wrong");
endmodule

`default_nettype wire

/* tb/bt4_pins.sv */
`timescale 1ns/10ps
`default_nettype none

// far-side pins: both idle high, edges launched just after a rising clock edge
module bt4_pins (
  input  wire logic clk,
  output logic      pin_level,
  output logic      trig_level
);
  initial begin
    pin_level  = 1'b1;
    trig_level = 1'b1;
  end
  // one falling edge on the trigger pin, held low long enough to be seen
  task automatic trig_fall();
    @(posedge clk) trig_level <= 1'b0;
    repeat (3) @(posedge clk);
    trig_level <= 1'b1;
  endtask
  // direction level for up/down counting: 1 up, 0 down
  task automatic set_dir(input logic up);
    @(posedge clk) trig_level <= up;
  endtask
  // count pulses four clocks low, five high, so each edge is sampled once
  task automatic count_pulses(input int n);
    repeat (n) begin
      @(posedge clk) pin_level <= 1'b0;
      repeat (4) @(posedge clk);
      pin_level <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

`default_nettype wire

/* tb/banked_timer_four_test.sv */
`timescale 1ns/10ps
`default_nettype none

module banked_timer_four_test;
  localparam logic [7:0] CT = bt4_pkg::BT4_IDX_CTRL;   // short aliases keep calls on one line
  localparam logic [7:0] MD = bt4_pkg::BT4_IDX_MODE;
  localparam logic [7:0] RLO = bt4_pkg::BT4_IDX_RLD_LO;
  localparam logic [7:0] RHI = bt4_pkg::BT4_IDX_RLD_HI;
  localparam logic [7:0] CLO = bt4_pkg::BT4_IDX_CNT_LO;
  localparam logic [7:0] CHI = bt4_pkg::BT4_IDX_CNT_HI;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0]  sel = 4'h0;
  wire logic [31:0] dat_o;
  wire logic   ack, pin_o, oe, trig, cnt_drv, run, irq, prio;
  wire logic [3:0]  cfg;
  wire logic   cnt_pin = oe ? pin_o : cnt_drv;  // shared wire: design drives it in clock-out
  int          failures = 0;
  int          tests_run = 0;

  always #10 clk = ~clk;

  bt4_banked_timer_four #(.PRESCALE(bt4_pkg::BT4_PRESCALE)) u_bt4_banked_timer_four (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .count_io_pin_i(cnt_pin), .count_io_pin_o(pin_o), .count_io_pin_oe(oe),
    .external_trigger_pin_i(trig), .paired_pwm_run(run), .pwm_channel_cfg(cfg),
    .timer_irq(irq), .timer_irq_priority(prio));
  bt4_pins u_bt4_pins (.clk(clk), .pin_level(cnt_drv), .trig_level(trig));

  task automatic finish_test();
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle: hold until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat_i <= {24'h00_0000, d};
    sel <= 4'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) failures++;
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] i, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(nm, q, e);
  endtask
  task automatic rdv(input logic [7:0] i, output logic [7:0] q);
    bus(1'b0, i, 8'h00, q);
  endtask
  // let register updates reach the outputs
  task automatic st();
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset();
    rd("ie2", bt4_pkg::BT4_IDX_IE2, 8'h00);
    rd("ip2", bt4_pkg::BT4_IDX_IP2, 8'h00);
    rd("bank", bt4_pkg::BT4_IDX_BANK, 8'h02);
    wr(CT, 8'h04);
    st();
    chk("run unbanked", run, 1'b0);
    rd("ctrl unbanked", CT, 8'h00);
    rd("unmapped", 8'hF0, 8'h00);
    wr(bt4_pkg::BT4_IDX_BANK, 8'h04);
    wr(CT, 8'h3B);
    rd("ctrl", CT, 8'h0B);
    wr(MD, 8'h7C);
    rd("mode", MD, 8'h3C);
    chk("pwm cfg", cfg, 4'hF);
    wr(MD, 8'h00);
    wr(CT, 8'h00);
  endtask
  task automatic t_run();
    logic [7:0] q;
    wr(RLO, 8'hF0);
    wr(RHI, 8'hFF);
    wr(CLO, 8'hFE);
    wr(CHI, 8'hFF);
    wr(MD, 8'h80);
    repeat (30) @(posedge clk);
    rd("frozen", CLO, 8'hFE);
    wr(CT, 8'h04);
    // read while running: a stop write of zero would clear the flag itself
    rd("ovf flag", CT, 8'h84);
    rd("sticky", CT, 8'h84);
    wr(CT, 8'h00);
    rdv(CLO, q);
    chk("reload lo", q[7:4], 4'hF);
    rd("reload hi", CHI, 8'hFF);
    rd("flag clear", CT, 8'h00);
    wr(CLO, 8'h00);
    wr(CHI, 8'h00);
    wr(MD, 8'h00);
    wr(CT, 8'h04);
    repeat (120) @(posedge clk);
    wr(CT, 8'h00);
    rdv(CLO, q);
    chk("div12", q >= 8'd9 && q <= 8'd11, 1'b1);
  endtask
  task automatic t_capture();
    wr(CLO, 8'h34);
    wr(CHI, 8'h12);
    wr(CT, 8'h09);
    u_bt4_pins.trig_fall();
    rd("cap lo", RLO, 8'h34);
    rd("cap hi", RHI, 8'h12);
    rd("event flag", CT, 8'h49);
    wr(CT, 8'h01);
    wr(CLO, 8'h78);
    u_bt4_pins.trig_fall();
    rd("ignored cap", RLO, 8'h34);
    rd("no event", CT, 8'h01);
    // reload mode: an enabled trigger edge reloads even while stopped
    wr(CT, 8'h08);
    u_bt4_pins.trig_fall();
    rd("trig reload", CLO, 8'h34);
    rd("reload event", CT, 8'h48);
    wr(CT, 8'h00);
  endtask
  task automatic t_irq();
    rd("status", bt4_pkg::BT4_IDX_STAT, 8'h03);
    wr(bt4_pkg::BT4_IDX_IEN, 8'h03);
    st();
    chk("irq gated", irq, 1'b0);
    wr(bt4_pkg::BT4_IDX_IE2, 8'h80);
    st();
    chk("irq on", irq, 1'b1);
    wr(bt4_pkg::BT4_IDX_IEN, 8'h00);
    st();
    chk("irq masked", irq, 1'b0);
    wr(bt4_pkg::BT4_IDX_IEN, 8'h02);
    wr(bt4_pkg::BT4_IDX_ICLR, 8'h02);
    st();
    chk("irq cleared", irq, 1'b0);
    rd("status left", bt4_pkg::BT4_IDX_STAT, 8'h01);
    rd("clear reads 0", bt4_pkg::BT4_IDX_ICLR, 8'h00);
    wr(bt4_pkg::BT4_IDX_IP2, 8'h80);
    st();
    chk("priority", prio, 1'b1);
    rd("ip2 back", bt4_pkg::BT4_IDX_IP2, 8'h80);
  endtask
  task automatic t_counter();
    wr(CLO, 8'h00);
    wr(CHI, 8'h00);
    wr(CT, 8'h06);
    u_bt4_pins.count_pulses(5);
    wr(CT, 8'h00);
    rd("pin events", CLO, 8'h05);
  endtask
  task automatic t_down();
    logic [7:0] q;
    u_bt4_pins.set_dir(1'b0);
    wr(RLO, 8'h10);
    wr(RHI, 8'h00);
    wr(CLO, 8'h12);
    wr(CHI, 8'h00);
    wr(MD, 8'h81);
    wr(CT, 8'h04);
    wr(CT, 8'h00);
    rdv(CT, q);
    chk("down ovf", q[7], 1'b1);
    rd("down reload", CHI, 8'hFF);
    u_bt4_pins.set_dir(1'b1);
  endtask
  task automatic t_clkout();
    logic p;
    int n;
    wr(RLO, 8'hFE);
    wr(RHI, 8'hFF);
    wr(MD, 8'h82);
    wr(CT, 8'h04);
    st();
    chk("clock out oe", oe, 1'b1);
    for (int k = 0; k < 2; k++) begin
      p = pin_o;
      n = 0;
      while (pin_o === p && n < 50) begin
        @(negedge clk);
        n++;
      end
    end
    chk("half period", 16'(n), 16'd4);
    rd("no flag", CT, 8'h04);
    wr(CT, 8'h00);
    wr(MD, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_run();
    t_capture();
    t_irq();
    t_counter();
    t_down();
    t_clkout();
    finish_test();
  end
  // hang guard well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule

bind bt4_banked_timer_four bt4_asserts u_bt4_asserts (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .count_io_pin_o(count_io_pin_o), .count_io_pin_oe(count_io_pin_oe),
  .paired_pwm_run(paired_pwm_run), .pwm_channel_cfg(pwm_channel_cfg),
  .timer_irq(timer_irq), .timer_irq_priority(timer_irq_priority));

`default_nettype wire
